// *** fmss_defines.svh ***
// register offsets, field positions, reset values and op codes of the fp/media state block
`ifndef FMSS_DEFINES_SVH
`define FMSS_DEFINES_SVH

`define FMSS_ADDR_W        11
`define FMSS_OFF_CMD       11'h000
`define FMSS_OFF_FCW       11'h004
`define FMSS_OFF_FSW       11'h008
`define FMSS_OFF_FTW       11'h00C
`define FMSS_OFF_MCS       11'h010
`define FMSS_OFF_OPC       11'h014
`define FMSS_OFF_IP_LO     11'h018
`define FMSS_OFF_IP_HI     11'h01C
`define FMSS_OFF_DP_LO     11'h020
`define FMSS_OFF_DP_HI     11'h024
`define FMSS_OFF_OPND_LO   11'h028
`define FMSS_OFF_OPND_HI   11'h02C
`define FMSS_OFF_OPND_X    11'h030
`define FMSS_OFF_CTRL      11'h034
`define FMSS_OFF_AIP_LO    11'h038
`define FMSS_OFF_AIP_HI    11'h03C
`define FMSS_OFF_ADP_LO    11'h040
`define FMSS_OFF_ADP_HI    11'h044
`define FMSS_OFF_VEC       11'h048
`define FMSS_OFF_FLAGS     11'h04C
`define FMSS_IMG_WORDS     160

`define FMSS_OP_PINT       4'h1
`define FMSS_OP_FPEXEC     4'h2
`define FMSS_OP_FST_CHK    4'h3
`define FMSS_OP_FST_UNCHK  4'h4
`define FMSS_OP_FRESTORE   4'h5
`define FMSS_OP_ENV_STORE  4'h6
`define FMSS_OP_ENV_LOAD   4'h7
`define FMSS_OP_EXT_STORE  4'h8
`define FMSS_OP_EXT_REST   4'h9

`define FMSS_FSW_ES        7
`define FMSS_CTRL_LEGACY   8
`define FMSS_CTRL_OP32     9
`define FMSS_CTRL_MEMOP    10
`define FMSS_ENV_HW        7
`define FMSS_FULL_HW       47
`define FMSS_EXT_FPR_BASE  8
`define FMSS_EXT_VEC_BASE  32

`define FMSS_FCW_RST       16'h0000
`define FMSS_FTW_EMPTY     16'hFFFF
`define FMSS_MCS_RST       32'h00000000
`define FMSS_PINT_EXP      16'hFFFF

`endif

// *** fmss_pkg.sv ***
// types shared by the fp/media state block
package fmss_pkg;
  `include "fmss_defines.svh"

  typedef struct packed {
    logic                     read;
    logic                     write;
    logic [`FMSS_ADDR_W-1:0]  address;
    logic [31:0]              writedata;
    logic [3:0]               byteenable;
  } fmss_av_req_t;

  typedef struct packed {
    logic [15:0][255:0]                 vec;
    logic [7:0][79:0]                   fpr;
    logic [`FMSS_IMG_WORDS-1:0][31:0]   img;
    logic [15:0]                        fp_control_word;
    logic [15:0]                        fp_status_word;
    logic [15:0]                        fp_tag_word;
    logic [31:0]                        mcs;
    logic [10:0]                        opc;
    logic [63:0]                        ip;
    logic [63:0]                        dp;
    logic [31:0]                        opnd_lo;
    logic [31:0]                        opnd_hi;
    logic [31:0]                        opnd_x;
    logic [31:0]                        ctrl;
    logic [63:0]                        arg_ip;
    logic [63:0]                        arg_dp;
    logic                               exc_sticky;
    logic                               exc;
    logic                               pend;
    logic                               ack;
    logic [31:0]                        rdata;
  } fmss_state_t;
endpackage

// *** fmss_state_save.sv ***
// fp / packed-integer / vector architectural state with save and restore images
`timescale 1ns/10ps
`default_nettype none
`include "fmss_defines.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------

module fmss_state_save (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire fmss_pkg::fmss_av_req_t av_req,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  output logic                       fp_exception_pulse
);

  fmss_pkg::fmss_state_t st_q;
  fmss_pkg::fmss_state_t nxt;
  logic                  bus_req;
  logic                  wr_go;
  logic                  cmd_fire;
  logic [3:0]            cmd_op;
  logic [3:0]            op;
  logic [31:0]           wr_old;
  logic [31:0]           wr_val;
  logic                  es;
  logic                  legacy;
  logic [2:0]            ri;
  logic [2:0]            ph;
  logic [2:0]            top_new;
  logic                  do_full;
  logic                  do_rest;
  logic [15:0]           st0_low;
  logic [10:0]           opc_arg;

  // ------------------------------------------------------------
  // image and bus helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] img_hw(input fmss_pkg::fmss_state_t s, input int i);
    logic [2:0] p;
    int         j;
    j = i - `FMSS_ENV_HW;
    p = s.fp_status_word[13:11] + 3'(j / 5);
    case (i)
      0: img_hw = s.fp_control_word;
      1: img_hw = s.fp_status_word;
      2: img_hw = s.fp_tag_word;
      3: img_hw = s.ip[15:0];
      4: img_hw = s.ip[47:32];
      5: img_hw = s.dp[15:0];
      6: img_hw = s.dp[47:32];
      default: img_hw = (i < `FMSS_FULL_HW) ? s.fpr[p][16*(j%5) +: 16] : 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] buf_hw(input fmss_pkg::fmss_state_t s, input int i);
    buf_hw = s.img[i/2][16*(i%2) +: 16];
  endfunction

  function automatic logic [31:0] rd_mux(input fmss_pkg::fmss_state_t s,
                                         input logic [`FMSS_ADDR_W-1:0] a);
    logic [7:0] wi;
    logic [3:0] vi;
    logic [2:0] vw;
    wi = a[9:2];
    vi = s.ctrl[3:0];
    vw = s.ctrl[6:4];
    case (a)
      `FMSS_OFF_CMD:     rd_mux = {31'h00000000, s.pend};
      `FMSS_OFF_FCW:     rd_mux = {16'h0000, s.fp_control_word};
      `FMSS_OFF_FSW:     rd_mux = {16'h0000, s.fp_status_word};
      `FMSS_OFF_FTW:     rd_mux = {16'h0000, s.fp_tag_word};
      `FMSS_OFF_MCS:     rd_mux = s.mcs;
      `FMSS_OFF_OPC:     rd_mux = {21'h000000, s.opc};
      `FMSS_OFF_IP_LO:   rd_mux = s.ip[31:0];
      `FMSS_OFF_IP_HI:   rd_mux = s.ip[63:32];
      `FMSS_OFF_DP_LO:   rd_mux = s.dp[31:0];
      `FMSS_OFF_DP_HI:   rd_mux = s.dp[63:32];
      `FMSS_OFF_OPND_LO: rd_mux = s.opnd_lo;
      `FMSS_OFF_OPND_HI: rd_mux = s.opnd_hi;
      `FMSS_OFF_OPND_X:  rd_mux = s.opnd_x;
      `FMSS_OFF_CTRL:    rd_mux = s.ctrl;
      `FMSS_OFF_AIP_LO:  rd_mux = s.arg_ip[31:0];
      `FMSS_OFF_AIP_HI:  rd_mux = s.arg_ip[63:32];
      `FMSS_OFF_ADP_LO:  rd_mux = s.arg_dp[31:0];
      `FMSS_OFF_ADP_HI:  rd_mux = s.arg_dp[63:32];
      `FMSS_OFF_FLAGS:   rd_mux = {31'h00000000, s.exc_sticky};
      // upper vectors read as zero while only eight are reachable
      `FMSS_OFF_VEC:     rd_mux = (s.ctrl[`FMSS_CTRL_LEGACY] && vi[3]) ? 32'h00000000 :
                                  s.vec[vi][32*vw +: 32];
      default:           rd_mux = (a[10] && (wi < `FMSS_IMG_WORDS)) ? s.img[wi] : 32'h00000000;
    endcase
  endfunction

  assign st0_low = st_q.fpr[st_q.fp_status_word[13:11]][15:0];
  assign opc_arg = {st_q.opnd_x[18:16], st_q.opnd_x[31:24]};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt      = st_q;
    nxt.exc  = 1'b0;
    nxt.pend = 1'b0;
    nxt.ack  = 1'b0;
    bus_req  = av_req.read | av_req.write;
    wr_go    = av_req.write & st_q.ack;
    cmd_fire = wr_go && (av_req.address == `FMSS_OFF_CMD);
    cmd_op   = av_req.writedata[3:0];
    wr_old   = rd_mux(st_q, av_req.address);
    for (int b = 0; b < 4; b++) begin
      wr_val[8*b +: 8] = av_req.byteenable[b] ? av_req.writedata[8*b +: 8] : wr_old[8*b +: 8];
    end
    es      = st_q.fp_status_word[`FMSS_FSW_ES];
    legacy  = st_q.ctrl[`FMSS_CTRL_LEGACY];
    ri      = st_q.ctrl[2:0];
    ph      = 3'h0;
    top_new = 3'h0;
    do_full = 1'b0;
    do_rest = 1'b0;

    // one wait cycle, then the answer; the data is captured from flops
    if (bus_req && !st_q.ack) begin
      nxt.ack   = 1'b1;
      nxt.rdata = wr_old;
    end

    // tag word, pointers and opcode have no write decode
    if (wr_go) begin
      case (av_req.address)
        `FMSS_OFF_FCW:     nxt.fp_control_word = wr_val[15:0];
        `FMSS_OFF_FSW:     nxt.fp_status_word = wr_val[15:0];
        `FMSS_OFF_MCS:     nxt.mcs = wr_val;
        `FMSS_OFF_OPND_LO: nxt.opnd_lo = wr_val;
        `FMSS_OFF_OPND_HI: nxt.opnd_hi = wr_val;
        `FMSS_OFF_OPND_X:  nxt.opnd_x = wr_val;
        `FMSS_OFF_CTRL:    nxt.ctrl = wr_val;
        `FMSS_OFF_AIP_LO:  nxt.arg_ip[31:0] = wr_val;
        `FMSS_OFF_AIP_HI:  nxt.arg_ip[63:32] = wr_val;
        `FMSS_OFF_ADP_LO:  nxt.arg_dp[31:0] = wr_val;
        `FMSS_OFF_ADP_HI:  nxt.arg_dp[63:32] = wr_val;
        `FMSS_OFF_FLAGS:   if (wr_val[0]) nxt.exc_sticky = 1'b0;
        `FMSS_OFF_VEC: begin
          if (!(legacy && st_q.ctrl[3])) begin
            nxt.vec[st_q.ctrl[3:0]][32*st_q.ctrl[6:4] +: 32] = wr_val;
          end
        end
        default: begin
          if (av_req.address[10] && (av_req.address[9:2] < `FMSS_IMG_WORDS)) begin
            nxt.img[av_req.address[9:2]] = wr_val;
          end
        end
      endcase
    end

    // a checked store held back by an exception runs in the following cycle
    if (st_q.pend) begin
      op = `FMSS_OP_FST_UNCHK;
    end else if (cmd_fire) begin
      op = cmd_op;
    end else begin
      op = 4'h0;
    end

    case (op)
      `FMSS_OP_PINT: begin
        if (es) begin
          nxt.exc = 1'b1;
        end else begin
          nxt.fpr[ri]       = {`FMSS_PINT_EXP, st_q.opnd_hi, st_q.opnd_lo};
          nxt.fp_status_word[13:11]    = 3'h0;
          nxt.fp_tag_word           = 16'h0000;
        end
        // exception flags in the status word are left alone
      end
      `FMSS_OP_FPEXEC: begin
        nxt.fpr[ri]       = {st_q.opnd_x[15:0], st_q.opnd_hi, st_q.opnd_lo};
        nxt.fp_tag_word[2*ri +: 2] = 2'b00;
        nxt.ip            = st_q.arg_ip;
        if (st_q.ctrl[`FMSS_CTRL_MEMOP]) nxt.dp = st_q.arg_dp;
        nxt.opc           = opc_arg;
      end
      `FMSS_OP_FST_CHK: begin
        if (es) begin
          nxt.exc  = 1'b1;
          nxt.pend = 1'b1;
        end else begin
          do_full = 1'b1;
        end
      end
      `FMSS_OP_FST_UNCHK: do_full = 1'b1;
      `FMSS_OP_FRESTORE:  do_rest = 1'b1;
      `FMSS_OP_ENV_STORE: begin
        for (int k = 0; k < 3; k++) begin
          nxt.img[k] = {img_hw(st_q, 2*k+1), img_hw(st_q, 2*k)};
        end
        nxt.img[3][15:0] = img_hw(st_q, 6);
      end
      `FMSS_OP_ENV_LOAD:  do_rest = 1'b1;
      `FMSS_OP_EXT_STORE: begin
        // no exception check and no tag change
        nxt.img[0] = {st_q.fp_status_word, st_q.fp_control_word};
        nxt.img[1] = {5'h00, es ? st_q.opc : 11'h000, st_q.fp_tag_word};
        nxt.img[2] = es ? st_q.ip[31:0] : 32'h00000000;
        nxt.img[4] = es ? st_q.dp[31:0] : 32'h00000000;
        if (st_q.ctrl[`FMSS_CTRL_OP32]) begin
          nxt.img[3] = es ? {16'h0000, st_q.ip[47:32]} : 32'h00000000;
          nxt.img[5] = es ? {16'h0000, st_q.dp[47:32]} : 32'h00000000;
        end else begin
          nxt.img[3] = es ? st_q.ip[63:32] : 32'h00000000;
          nxt.img[5] = es ? st_q.dp[63:32] : 32'h00000000;
        end
        nxt.img[6] = st_q.mcs;
        nxt.img[7] = 32'h00000000;
        for (int r = 0; r < 8; r++) begin
          nxt.img[`FMSS_EXT_FPR_BASE+3*r]   = st_q.fpr[r][31:0];
          nxt.img[`FMSS_EXT_FPR_BASE+3*r+1] = st_q.fpr[r][63:32];
          nxt.img[`FMSS_EXT_FPR_BASE+3*r+2] = {16'h0000, st_q.fpr[r][79:64]};
        end
        for (int v = 0; v < 128; v++) begin
          nxt.img[`FMSS_EXT_VEC_BASE+v] = st_q.vec[v/8][32*(v%8) +: 32];
        end
      end
      `FMSS_OP_EXT_REST: begin
        nxt.fp_control_word = st_q.img[0][15:0];
        nxt.fp_status_word = st_q.img[0][31:16];
        nxt.fp_tag_word = st_q.img[1][15:0];
        nxt.mcs = st_q.img[6];
        if (st_q.img[0][16+`FMSS_FSW_ES]) begin
          nxt.opc = st_q.img[1][26:16];
          if (st_q.ctrl[`FMSS_CTRL_OP32]) begin
            nxt.ip = {16'h0000, st_q.img[3][15:0], st_q.img[2]};
            nxt.dp = {16'h0000, st_q.img[5][15:0], st_q.img[4]};
          end else begin
            nxt.ip = {st_q.img[3], st_q.img[2]};
            nxt.dp = {st_q.img[5], st_q.img[4]};
          end
        end
        for (int r = 0; r < 8; r++) begin
          nxt.fpr[r] = {st_q.img[`FMSS_EXT_FPR_BASE+3*r+2][15:0],
                        st_q.img[`FMSS_EXT_FPR_BASE+3*r+1],
                        st_q.img[`FMSS_EXT_FPR_BASE+3*r]};
        end
        for (int v = 0; v < 128; v++) begin
          nxt.vec[v/8][32*(v%8) +: 32] = st_q.img[`FMSS_EXT_VEC_BASE+v];
        end
      end
      default: ;
    endcase

    // full store: environment then stack-ordered data; vectors not touched
    if (do_full) begin
      for (int k = 0; k < 24; k++) begin
        nxt.img[k] = {img_hw(st_q, 2*k+1), img_hw(st_q, 2*k)};
      end
      nxt.fp_tag_word = `FMSS_FTW_EMPTY;
    end

    // restore and environment load share the environment part
    if (do_rest) begin
      nxt.fp_control_word = buf_hw(st_q, 0);
      nxt.fp_status_word = buf_hw(st_q, 1);
      nxt.fp_tag_word = buf_hw(st_q, 2);
      nxt.ip  = {16'h0000, buf_hw(st_q, 4), 16'h0000, buf_hw(st_q, 3)};
      nxt.dp  = {16'h0000, buf_hw(st_q, 6), 16'h0000, buf_hw(st_q, 5)};
      top_new = st_q.img[0][29:27];
      if (op == `FMSS_OP_FRESTORE) begin
        for (int j = 0; j < 40; j++) begin
          ph = top_new + 3'(j / 5);
          nxt.fpr[ph][16*(j%5) +: 16] = buf_hw(st_q, `FMSS_ENV_HW + j);
        end
      end
    end

    // an exception raised in the cycle software clears the flag still sticks
    if (nxt.exc) nxt.exc_sticky = 1'b1;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q     <= '0;
      st_q.fp_control_word <= `FMSS_FCW_RST;
      st_q.fp_tag_word <= `FMSS_FTW_EMPTY;
      st_q.mcs <= `FMSS_MCS_RST;
    end else begin
      st_q <= nxt;
    end
  end

  assign readdata           = st_q.rdata;
  assign waitrequest        = bus_req & ~st_q.ack;
  assign fp_exception_pulse = st_q.exc;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_legacy_vec_guard: assert property (
    (wr_go && av_req.address == `FMSS_OFF_VEC && legacy && st_q.ctrl[3]) |=> $stable(st_q.vec))
    else $error("upper vector written in legacy mode");

  a_pint_top_tags: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_PINT && !es) |=> (st_q.fp_status_word[13:11] == 3'h0 && st_q.fp_tag_word == 16'h0000))
    else $error("packed op did not reset top or tags");

  a_pint_no_flags: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_PINT && !es)
      |=> (!fp_exception_pulse && st_q.fp_status_word[5:0] == $past(st_q.fp_status_word[5:0])))
    else $error("packed op touched fp flags");

  a_pint_raise_exc: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_PINT && es) |=> (fp_exception_pulse && $stable(st_q.fpr)))
    else $error("pending exception not delivered by packed op");

  a_opcode_form: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_FPEXEC) |=> (st_q.opc == $past(opc_arg)))
    else $error("opcode register formed wrongly");

  a_checked_order: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_FST_CHK && es)
      |=> (fp_exception_pulse && $stable(st_q.img)) ##1 (st_q.fp_tag_word == `FMSS_FTW_EMPTY))
    else $error("checked store wrote before exception");

  a_unchecked_quiet: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_FST_UNCHK) |=> !fp_exception_pulse)
    else $error("unchecked store raised exception");

  a_full_tags_empty: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_FST_UNCHK) |=> (st_q.fp_tag_word == `FMSS_FTW_EMPTY))
    else $error("tags not empty after full store");

  a_full_keeps_vec: assert property (
    (cmd_fire && (cmd_op == `FMSS_OP_FST_UNCHK || cmd_op == `FMSS_OP_FRESTORE))
      |=> $stable(st_q.vec))
    else $error("full store or restore changed vectors");

  a_stack_order: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_FST_UNCHK) |=> (st_q.img[3][31:16] == $past(st0_low)))
    else $error("image data not in stack order");

  a_ext_ptr_gate: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_EXT_STORE && !es)
      |=> (st_q.img[2] == 32'h00000000 && st_q.img[5] == 32'h00000000))
    else $error("pointers stored without summary bit");

  a_ext_keeps_tags: assert property (
    (cmd_fire && cmd_op == `FMSS_OP_EXT_STORE) |=> ($stable(st_q.fp_tag_word) && !fp_exception_pulse))
    else $error("extended store changed tags or raised exception");

endmodule
`default_nettype wire

// *** fmss_testbench.sv ***
// self-checking bench for the fp / packed-integer / vector state block
`timescale 1ns/10ps
`default_nettype none
`include "fmss_defines.svh"
module testbench;
  // ------------------------------------------------------------
  // signals and device under test
  // ------------------------------------------------------------
  logic                   clock;
  logic                   nrst;
  fmss_pkg::fmss_av_req_t av_req;
  logic [31:0]            readdata;
  logic                   waitrequest;
  logic                   fp_exception_pulse;
  int                     num_errors;
  int                     tests_run;
  int                     pulses;
  logic [31:0]            rv;

  fmss_state_save uut (
    .clock              (clock),
    .nrst               (nrst),
    .av_req             (av_req),
    .readdata           (readdata),
    .waitrequest        (waitrequest),
    .fp_exception_pulse (fp_exception_pulse)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // counted on the falling edge so the value is settled when read after a rising edge
  always @(negedge clock) begin
    if (fp_exception_pulse === 1'b1) pulses++;
  end

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks made %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request is held until waitrequest is seen low, then released after that edge
  task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d);
    int   n;
    logic done;
    done = 1'b0;
    av_req.read       <= ~w;
    av_req.write      <= w;
    av_req.address    <= a;
    av_req.writedata  <= d;
    av_req.byteenable <= 4'hF;
    // waitrequest and readdata only change after the edge, so both are read at the edge
    for (n = 0; n < 20 && !done; n++) begin
      @(posedge clock);
      done = (waitrequest === 1'b0);
    end
    rv = readdata;
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
    if (!done) begin
      num_errors++;
      $display("BAD bus answer expected %h seen %h", 1'b0, waitrequest);
      finish_test();
    end
    @(posedge clock);
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [10:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(what, rv, exp);
  endtask

  task automatic op(input logic [3:0] code);
    wr(`FMSS_OFF_CMD, {28'h0000000, code});
  endtask

  function automatic logic [10:0] im(input int k);
    return 11'h400 + 11'(4 * k);
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    av_req = '0;
    nrst = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd("fp_control_word", `FMSS_OFF_FCW, 32'h00000000);
    rd("fp_status_word", `FMSS_OFF_FSW, 32'h00000000);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h0000FFFF);
    rd("media_ctrl_status", `FMSS_OFF_MCS, 32'h00000000);
    rd("unmapped", 11'h050, 32'h00000000);
    $display("test reset finished");
    wr(`FMSS_OFF_FCW, 32'h0000037F);
    rd("fp_control_word", `FMSS_OFF_FCW, 32'h0000037F);
    wr(`FMSS_OFF_MCS, 32'hA5A55A5A);
    rd("media_ctrl_status", `FMSS_OFF_MCS, 32'hA5A55A5A);
    wr(`FMSS_OFF_FTW, 32'h00001234);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h0000FFFF);
    wr(`FMSS_OFF_OPC, 32'h000007FF);
    rd("last opcode", `FMSS_OFF_OPC, 32'h00000000);
    wr(`FMSS_OFF_IP_LO, 32'h12345678);
    rd("instr pointer lo", `FMSS_OFF_IP_LO, 32'h00000000);
    wr(11'h050, 32'hFFFFFFFF);
    rd("unmapped", 11'h050, 32'h00000000);
    $display("test access finished");
    // fp instruction on reg 5 with memory operand, opcode bytes D9 F8
    wr(`FMSS_OFF_CTRL, 32'h00000405);
    wr(`FMSS_OFF_OPND_LO, 32'h00000000);
    wr(`FMSS_OFF_OPND_HI, 32'h00000000);
    wr(`FMSS_OFF_OPND_X, 32'hF8D90000);
    wr(`FMSS_OFF_AIP_LO, 32'h33334444);
    wr(`FMSS_OFF_AIP_HI, 32'h11112222);
    wr(`FMSS_OFF_ADP_LO, 32'h77778888);
    wr(`FMSS_OFF_ADP_HI, 32'h55556666);
    op(`FMSS_OP_FPEXEC);
    rd("last opcode", `FMSS_OFF_OPC, 32'h000001F8);
    rd("instr pointer lo", `FMSS_OFF_IP_LO, 32'h33334444);
    rd("instr pointer hi", `FMSS_OFF_IP_HI, 32'h11112222);
    rd("data pointer lo", `FMSS_OFF_DP_LO, 32'h77778888);
    rd("data pointer hi", `FMSS_OFF_DP_HI, 32'h55556666);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h0000F3FF);
    $display("test fp_exec finished");
    // top 5 and two sticky flags: packed-int op must clear top only
    wr(`FMSS_OFF_FSW, 32'h00002841);
    wr(`FMSS_OFF_CTRL, 32'h00000002);
    wr(`FMSS_OFF_OPND_LO, 32'h89ABCDEF);
    wr(`FMSS_OFF_OPND_HI, 32'h01234567);
    op(`FMSS_OP_PINT);
    rd("fp_status_word", `FMSS_OFF_FSW, 32'h00000041);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h00000000);
    chk("exception pulses", 32'(pulses), 32'h00000000);
    $display("test packed_int finished");
    // top 3 puts physical reg 2 last in the image
    wr(`FMSS_OFF_CTRL, 32'h00000029);
    wr(`FMSS_OFF_VEC, 32'hDEADBEEF);
    wr(`FMSS_OFF_FSW, 32'h00001800);
    op(`FMSS_OP_FST_UNCHK);
    rd("image 0", im(0), 32'h1800037F);
    rd("image 1", im(1), 32'h44440000);
    rd("image 2", im(2), 32'h88882222);
    rd("image 3", im(3), 32'h00006666);
    rd("image 21", im(21), 32'h89ABCDEF);
    rd("image 22", im(22), 32'h01234567);
    rd("image 23", im(23), 32'h0000FFFF);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h0000FFFF);
    rd("vector word", `FMSS_OFF_VEC, 32'hDEADBEEF);
    wr(`FMSS_OFF_CTRL, 32'h00000129);
    rd("legacy upper vector", `FMSS_OFF_VEC, 32'h00000000);
    wr(`FMSS_OFF_VEC, 32'h0BADF00D);
    chk("exception pulses", 32'(pulses), 32'h00000000);
    $display("test full_store finished");
    wr(im(3), 32'hAAAAAAAA);
    wr(im(4), 32'h55555555);
    wr(`FMSS_OFF_FCW, 32'h0000027F);
    op(`FMSS_OP_ENV_STORE);
    rd("image 0", im(0), 32'h1800027F);
    rd("image 3", im(3), 32'hAAAA6666);
    rd("image 4", im(4), 32'h55555555);
    wr(im(0), 32'h0000007F);
    wr(im(1), 32'hABCD5555);
    op(`FMSS_OP_ENV_LOAD);
    rd("fp_control_word", `FMSS_OFF_FCW, 32'h0000007F);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h00005555);
    rd("instr pointer lo", `FMSS_OFF_IP_LO, 32'h0000ABCD);
    rd("instr pointer hi", `FMSS_OFF_IP_HI, 32'h00002222);
    $display("test environment finished");
    op(`FMSS_OP_EXT_STORE);
    rd("ext image 1", im(1), 32'h00005555);
    rd("ext image 2", im(2), 32'h00000000);
    rd("ext image 6", im(6), 32'hA5A55A5A);
    wr(`FMSS_OFF_FSW, 32'h00000080);
    op(`FMSS_OP_EXT_STORE);
    rd("ext image 2", im(2), 32'h0000ABCD);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h00005555);
    chk("exception pulses", 32'(pulses), 32'h00000000);
    $display("test ext_store finished");
    // summary bit set: only the checked store and the packed-int op deliver it
    wr(`FMSS_OFF_FCW, 32'h00000111);
    op(`FMSS_OP_FST_CHK);
    repeat (2) @(posedge clock);
    chk("exception pulses", 32'(pulses), 32'h00000001);
    rd("image 0", im(0), 32'h00800111);
    op(`FMSS_OP_FST_UNCHK);
    repeat (2) @(posedge clock);
    chk("exception pulses", 32'(pulses), 32'h00000001);
    op(`FMSS_OP_PINT);
    chk("exception pulses", 32'(pulses), 32'h00000002);
    rd("fp_tag_word", `FMSS_OFF_FTW, 32'h0000FFFF);
    rd("exception sticky", `FMSS_OFF_FLAGS, 32'h00000001);
    wr(`FMSS_OFF_FLAGS, 32'h00000001);
    rd("exception sticky", `FMSS_OFF_FLAGS, 32'h00000000);
    $display("test pending finished");
    wr(im(0), 32'h00000123);
    op(`FMSS_OP_FRESTORE);
    rd("fp_control_word", `FMSS_OFF_FCW, 32'h00000123);
    wr(`FMSS_OFF_CTRL, 32'h00000029);
    rd("vector word", `FMSS_OFF_VEC, 32'hDEADBEEF);
    wr(im(0), 32'h00000000);
    wr(im(6), 32'h00001F80);
    op(`FMSS_OP_EXT_REST);
    rd("media_ctrl_status", `FMSS_OFF_MCS, 32'h00001F80);
    rd("instr pointer lo", `FMSS_OFF_IP_LO, 32'h0000ABCD);
    $display("test restore finished");
    // 32-bit operands in 64-bit mode keep only selector:offset pointers
    wr(`FMSS_OFF_CTRL, 32'h00000200);
    op(`FMSS_OP_FPEXEC);
    wr(`FMSS_OFF_FSW, 32'h00000080);
    op(`FMSS_OP_EXT_STORE);
    rd("ext image 2", im(2), 32'h33334444);
    rd("ext image 3", im(3), 32'h00002222);
    wr(im(3), 32'hFFFF2222);
    op(`FMSS_OP_EXT_REST);
    rd("instr pointer lo", `FMSS_OFF_IP_LO, 32'h33334444);
    rd("instr pointer hi", `FMSS_OFF_IP_HI, 32'h00002222);
    $display("test selector_offset finished");
    finish_test();
  end
endmodule
`default_nettype wire
